// [hw/dio_ports_with_sample_counter.sv]
// Three-port digital I/O with direction control and the sample counter
// What this block does
// (R1) Three byte ports, direction at offset 11
// (R2) Third port splits into two nibbles
// (R3) Direction bits 4,3,1,0: A, C-high, B, C-low
// (R4) Direction zero drives, one listens
// (R5) Power-up: all inputs, outputs cleared
// (R6) Switching to output clears that output register
// (R7) Output mode reads back the output register
// (R8) Bit 7 selects port or counter lines
// (R9) Counter mode: gate, gate, clock in; pulse out
// (R10) 24-bit divide-by-n down counter
// (R11) Counter clock 10 or 1 MHz, offset-4 bit 5
// (R12) Ungated counter runs freely
// (R13) Zero gives one-period pulse, then reload
// (R14) Pulse rate is clock over divisor
// (R15) Pulse triggers conversion when enabled and selected
// (R16) Offset-15 control: load, clear, enable, gate, latch
// (R17) Input mode reads the external line levels
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dio_ports_with_sample_counter (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [dio_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dio_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [23:0] line_in,
   output logic [23:0] line_out,
   output logic [23:0] line_oe_n,
   output logic conv_trigger
);

   // ==========================================================
   // Reset release
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // ==========================================================
   // Write channel: address and data taken in either order
   logic aw_held_r;
   logic w_held_r;
   logic [dio_pkg::ADDR_W-1:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   wire logic aw_fire;
   wire logic w_fire;
   wire logic wr_go;
   wire logic [dio_pkg::ADDR_W-1:0] wr_addr;
   wire logic [7:0] wr_data;
   wire logic wr_lane;
   wire logic [3:0] wr_idx;
   wire logic wr_mapped;

   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready = ~w_held_r & ~bvalid_r;
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire = s_axi_wvalid & s_axi_wready;
   assign wr_go = (aw_held_r | aw_fire) & (w_held_r | w_fire);
   assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
   assign wr_data = w_held_r ? w_data_r : s_axi_wdata[7:0];
   assign wr_lane = w_held_r ? w_strb_r : s_axi_wstrb[0];
   assign wr_idx = wr_addr[5:2];
   assign wr_mapped = wr_idx == dio_pkg::IDX_CONFIG || wr_idx[3];

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 8'h00;
         w_strb_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= dio_pkg::RESP_OKAY;
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         bvalid_r <= 1'b1;
         bresp_r <= wr_mapped ? dio_pkg::RESP_OKAY : dio_pkg::RESP_SLVERR;
      end else begin
         if (aw_fire) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_strb_r <= s_axi_wstrb[0];
         end
         if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Register strobes; only byte lane 0 carries data
   wire logic wr_en;
   wire logic wr_cfg;
   wire logic wr_pa;
   wire logic wr_pb;
   wire logic wr_pc;
   wire logic wr_dir;
   wire logic wr_ctl;
   wire logic [2:0] wr_div;

   assign wr_en = wr_go & wr_lane;
   assign wr_cfg = wr_en && wr_idx == dio_pkg::IDX_CONFIG;
   assign wr_pa = wr_en && wr_idx == dio_pkg::IDX_PORT_A; // (R1)
   assign wr_pb = wr_en && wr_idx == dio_pkg::IDX_PORT_B; // (R1)
   assign wr_pc = wr_en && wr_idx == dio_pkg::IDX_PORT_C; // (R1)
   assign wr_dir = wr_en && wr_idx == dio_pkg::IDX_DIR; // (R1)
   assign wr_div[0] = wr_en && wr_idx == dio_pkg::IDX_CNT_LOW;
   assign wr_div[1] = wr_en && wr_idx == dio_pkg::IDX_CNT_MID;
   assign wr_div[2] = wr_en && wr_idx == dio_pkg::IDX_CNT_HIGH;
   // Commands for the second counter are not implemented and are ignored
   assign wr_ctl = wr_en && wr_idx == dio_pkg::IDX_CNT_CTL
      && !wr_data[dio_pkg::CTL_SEL_BIT]; // (R16)

   // ==========================================================
   // Configuration, direction and output registers
   logic [7:0] cfg_r;
   logic [7:0] dir_r;
   logic [23:0] port_out_r;
   logic [23:0] port_out_nxt;
   logic [23:0] divisor_r;
   wire logic [7:0] dir_new;
   wire logic [3:0] to_output;
   wire logic [23:0] clr_mask;
   wire logic port_func;
   wire logic dir_a;
   wire logic dir_b;
   wire logic dir_ch;
   wire logic dir_cl;

   assign dir_new = wr_data & dio_pkg::DIR_MASK;
   assign port_func = dir_r[dio_pkg::DIR_FUNC_SEL_BIT]; // (R8)
   assign dir_a = dir_r[dio_pkg::DIR_A_BIT]; // (R3)
   assign dir_b = dir_r[dio_pkg::DIR_B_BIT]; // (R3)
   assign dir_ch = dir_r[dio_pkg::DIR_CH_BIT]; // (R3) (R2)
   assign dir_cl = dir_r[dio_pkg::DIR_CL_BIT]; // (R3) (R2)

   // A one-to-zero direction edge means the port just became an output
   assign to_output[0] = wr_dir & dir_a & ~dir_new[dio_pkg::DIR_A_BIT];
   assign to_output[1] = wr_dir & dir_b & ~dir_new[dio_pkg::DIR_B_BIT];
   assign to_output[2] = wr_dir & dir_cl & ~dir_new[dio_pkg::DIR_CL_BIT];
   assign to_output[3] = wr_dir & dir_ch & ~dir_new[dio_pkg::DIR_CH_BIT];
   assign clr_mask = {{4{to_output[3]}}, {4{to_output[2]}},
      {8{to_output[1]}}, {8{to_output[0]}}}; // (R6) (R2)

   always_comb begin
      port_out_nxt = port_out_r;
      if (wr_pa) begin
         port_out_nxt[7:0] = wr_data;
      end
      if (wr_pb) begin
         port_out_nxt[15:8] = wr_data;
      end
      if (wr_pc) begin
         port_out_nxt[23:16] = wr_data;
      end
      port_out_nxt = port_out_nxt & ~clr_mask; // (R6)
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cfg_r <= dio_pkg::CFG_RESET;
         dir_r <= dio_pkg::DIR_RESET; // (R5)
         port_out_r <= dio_pkg::PORT_RESET; // (R5)
         divisor_r <= '0;
      end else begin
         port_out_r <= port_out_nxt;
         if (wr_cfg) begin
            cfg_r <= wr_data & dio_pkg::CFG_MASK;
         end
         if (wr_dir) begin
            dir_r <= dir_new;
         end
         if (wr_div[0]) begin
            divisor_r[7:0] <= wr_data;
         end
         if (wr_div[1]) begin
            divisor_r[15:8] <= wr_data;
         end
         if (wr_div[2]) begin
            divisor_r[23:16] <= wr_data;
         end
      end
   end

   // ==========================================================
   // Counter clock: 10 MHz or 1 MHz tick derived from the system clock
   logic [dio_pkg::PRESCALE_W-1:0] pre_r;
   wire logic [dio_pkg::PRESCALE_W-1:0] pre_last;
   wire logic tick;

   assign pre_last = cfg_r[dio_pkg::CFG_CLK_SEL_BIT]
      ? dio_pkg::PRESCALE_W'(dio_pkg::SLOW_DIV - 1)
      : dio_pkg::PRESCALE_W'(dio_pkg::FAST_DIV - 1); // (R11)
   assign tick = pre_r >= pre_last; // (R11)

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pre_r <= '0;
      end else begin
         pre_r <= tick ? '0 : pre_r + dio_pkg::PRESCALE_W'(1);
      end
   end

   // ==========================================================
   // Sample counter
   wire logic [23:0] ctr_latched;
   wire logic ctr_pulse;
   wire logic gate_level;

   // Gate is only available when the upper nibble is given to the counter
   assign gate_level = port_func ? 1'b1 : line_in[20]; // (R9)

   sample_counter #(
      .CNT_W(dio_pkg::CNT_W)
   ) u_counter (
      .sys_clk(sys_clk),
      .rst_n(rst_n_r),
      .tick(tick),
      .cmd_valid(wr_ctl),
      .cmd(dio_pkg::ctr_cmd_s'(wr_data[6:0])),
      .divisor(divisor_r),
      .gate_level(gate_level),
      .latched(ctr_latched),
      .pulse(ctr_pulse),
      .enabled()
   );

   // Conversion trigger on the counter's rising edge
   logic pulse_d_r;
   logic trig_r;
   wire logic trig_sel;

   assign trig_sel = cfg_r[dio_pkg::CFG_INT_EN_BIT]
      & ~cfg_r[dio_pkg::CFG_TRIG_SRC_BIT]; // (R15)

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pulse_d_r <= 1'b0;
         trig_r <= 1'b0;
      end else begin
         pulse_d_r <= ctr_pulse;
         trig_r <= ctr_pulse & ~pulse_d_r & trig_sel; // (R15)
      end
   end

   assign conv_trigger = trig_r;

   // ==========================================================
   // Pins: line 23 drives the counter pulse, 20..22 listen in counter mode
   wire logic [23:0] line_is_in;
   wire logic [23:0] line_drv;
   wire logic [23:0] line_rd;

   assign line_is_in = {port_func ? {4{dir_ch}} : 4'b0111,
      {4{dir_cl}}, {8{dir_b}}, {8{dir_a}}}; // (R4) (R9)
   assign line_drv = {port_func ? port_out_r[23:20]
      : {ctr_pulse, 3'b000}, port_out_r[19:0]}; // (R9)
   assign line_out = line_drv;
   assign line_oe_n = line_is_in; // (R4)

   genvar gi;
   generate
      for (gi = 0; gi < 24; gi++) begin : g_rd
         // Outputs read back what is held, inputs read the pin
         assign line_rd[gi] = line_is_in[gi] ? line_in[gi]
            : line_drv[gi]; // (R7) (R17)
      end
   endgenerate

   // ==========================================================
   // Read channel: answer one cycle after the address is taken
   logic rvalid_r;
   logic [7:0] rdata_r;
   logic [1:0] rresp_r;
   wire logic ar_fire;
   wire logic [3:0] rd_idx;
   wire logic rd_mapped;
   wire logic [7:0] rd_byte;

   assign s_axi_arready = ~rvalid_r;
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   assign rd_idx = s_axi_araddr[5:2];
   assign rd_mapped = rd_idx == dio_pkg::IDX_CONFIG || rd_idx[3];
   assign rd_byte =
      rd_idx == dio_pkg::IDX_CONFIG ? cfg_r :
      rd_idx == dio_pkg::IDX_PORT_A ? line_rd[7:0] :
      rd_idx == dio_pkg::IDX_PORT_B ? line_rd[15:8] :
      rd_idx == dio_pkg::IDX_PORT_C ? line_rd[23:16] :
      rd_idx == dio_pkg::IDX_DIR ? dir_r :
      rd_idx == dio_pkg::IDX_CNT_LOW ? ctr_latched[7:0] :
      rd_idx == dio_pkg::IDX_CNT_MID ? ctr_latched[15:8] :
      rd_idx == dio_pkg::IDX_CNT_HIGH ? ctr_latched[23:16] : 8'h00;

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
         rresp_r <= dio_pkg::RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_byte;
         rresp_r <= rd_mapped ? dio_pkg::RESP_OKAY : dio_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = {24'h00_0000, rdata_r};
   assign s_axi_rresp = rresp_r;

   // ==========================================================
   // Checks
   sequence s_dir_to_out_a;
      wr_dir && dir_a && !dir_new[dio_pkg::DIR_A_BIT];
   endsequence

   sequence s_out_a_clear;
      port_out_r[7:0] == 8'h00 && line_oe_n[7:0] == 8'h00;
   endsequence

   a_dir_clear_out: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      s_dir_to_out_a |=> s_out_a_clear) // (R6)
      else $error("port A not cleared on switch to output");

   a_counter_lines: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      !port_func |-> line_oe_n[23:20] == 4'b0111
      && line_out[23] == ctr_pulse) // (R9)
      else $error("upper nibble not in counter mode");

   a_readback_out: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      ar_fire && rd_idx == dio_pkg::IDX_PORT_B && !dir_b
      |=> s_axi_rdata[7:0] == $past(port_out_r[15:8])) // (R7)
      else $error("output readback wrong");

   a_read_input: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      ar_fire && rd_idx == dio_pkg::IDX_PORT_A && dir_a
      |=> s_axi_rdata[7:0] == $past(line_in[7:0])) // (R17)
      else $error("input readback wrong");

   a_trigger_cause: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      conv_trigger |-> $past(trig_sel) && $past(ctr_pulse, 1)
      && !$past(pulse_d_r)) // (R15)
      else $error("trigger without enabled counter edge");

   // Response follows the write and stands until bready is seen
   a_write_resp: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      wr_go || (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
      else $error("write response missing");

   a_tick_period: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      tick && !cfg_r[dio_pkg::CFG_CLK_SEL_BIT] && !wr_cfg
      // A switch to the slow rate inside the window may cancel the tick
      |=> !tick [*3] ##1 (tick || cfg_r[dio_pkg::CFG_CLK_SEL_BIT])) // (R11)
      else $error("fast tick period wrong");

endmodule // dio_ports_with_sample_counter
`default_nettype wire

// [hw/dio_pkg.sv]
// Shared constants and carrier types for the digital I/O and sample counter
package dio_pkg;

   // ==========================================================
   // Clocking
   localparam int unsigned SYS_CLK_HZ = 40_000_000;
   localparam int unsigned FAST_CLK_HZ = 10_000_000;
   localparam int unsigned SLOW_CLK_HZ = 1_000_000;
   localparam int unsigned FAST_DIV = SYS_CLK_HZ / FAST_CLK_HZ;
   localparam int unsigned SLOW_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;
   localparam int unsigned PRESCALE_W = 6;

   // ==========================================================
   // Register map: index = printed offset, byte address = 4 * index
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned CNT_W = 24;
   localparam logic [3:0] IDX_CONFIG = 4'h4;
   localparam logic [3:0] IDX_PORT_A = 4'h8;
   localparam logic [3:0] IDX_PORT_B = 4'h9;
   localparam logic [3:0] IDX_PORT_C = 4'hA;
   localparam logic [3:0] IDX_DIR = 4'hB;
   localparam logic [3:0] IDX_CNT_LOW = 4'hC;
   localparam logic [3:0] IDX_CNT_MID = 4'hD;
   localparam logic [3:0] IDX_CNT_HIGH = 4'hE;
   localparam logic [3:0] IDX_CNT_CTL = 4'hF;

   // ==========================================================
   // Field positions
   localparam int unsigned CFG_INT_EN_BIT = 0;
   localparam int unsigned CFG_TRIG_SRC_BIT = 4;
   localparam int unsigned CFG_CLK_SEL_BIT = 5;
   localparam int unsigned DIR_FUNC_SEL_BIT = 7;
   localparam int unsigned DIR_A_BIT = 4;
   localparam int unsigned DIR_CH_BIT = 3;
   localparam int unsigned DIR_B_BIT = 1;
   localparam int unsigned DIR_CL_BIT = 0;
   localparam int unsigned CTL_SEL_BIT = 7;

   // ==========================================================
   // Reset values and masks
   localparam logic [7:0] CFG_MASK = 8'h31;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] DIR_MASK = 8'h9B;
   localparam logic [7:0] DIR_RESET = 8'h9B;
   localparam logic [23:0] PORT_RESET = 24'h00_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Counter command byte, bits 6..0 of the control register
   typedef struct packed {
      logic latch;
      logic gate_dis;
      logic gate_en;
      logic cnt_dis;
      logic cnt_en;
      logic load;
      logic clear;
   } ctr_cmd_s;

endpackage

// [hw/sample_counter.sv]
// Divide-by-n down counter with gate, latch and one-period pulse output
`timescale 1ns/1ps
`default_nettype none
module sample_counter #(
   parameter int unsigned CNT_W = dio_pkg::CNT_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic cmd_valid,
   input wire dio_pkg::ctr_cmd_s cmd,
   input wire logic [CNT_W-1:0] divisor,
   input wire logic gate_level,
   output logic [CNT_W-1:0] latched,
   output logic pulse,
   output logic enabled
);

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] latch_r;
   logic en_r;
   logic gate_en_r;
   logic pulse_r;
   logic pulse_nxt;
   wire logic advance;
   wire logic at_zero;
   wire logic at_one;

   // ==========================================================
   // Counting
   // Gate only matters once enabled; a free-running count ignores it
   assign advance = en_r & tick & (~gate_en_r | gate_level); // (R12)
   assign at_zero = count_r == '0;
   assign at_one = count_r == CNT_W'(1);

   // Reload to divisor-1 from zero so each cycle spans divisor ticks
   always_comb begin
      count_nxt = count_r;
      pulse_nxt = pulse_r;
      if (cmd_valid && cmd.load) begin
         count_nxt = divisor;
         pulse_nxt = 1'b0;
      end else if (cmd_valid && cmd.clear) begin
         count_nxt = '0;
         pulse_nxt = 1'b0;
      end else if (advance) begin
         if (at_zero) begin
            count_nxt = divisor - CNT_W'(1); // (R13) (R14)
            pulse_nxt = 1'b0;
         end else begin
            count_nxt = count_r - CNT_W'(1); // (R10)
            pulse_nxt = at_one; // (R13)
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
         pulse_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   // ==========================================================
   // Command flags; a disable in the same byte wins over an enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_r <= 1'b0;
         gate_en_r <= 1'b0;
         latch_r <= '0;
      end else if (cmd_valid) begin
         if (cmd.cnt_dis) begin
            en_r <= 1'b0; // (R16)
         end else if (cmd.cnt_en) begin
            en_r <= 1'b1; // (R16)
         end
         if (cmd.gate_dis) begin
            gate_en_r <= 1'b0; // (R16)
         end else if (cmd.gate_en) begin
            gate_en_r <= 1'b1; // (R16)
         end
         if (cmd.latch) begin
            latch_r <= count_r; // (R16)
         end
      end
   end

   assign latched = latch_r;
   assign pulse = pulse_r;
   assign enabled = en_r;

   // ==========================================================
   // Checks
   a_hold_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !en_r && !cmd_valid |=> $stable(count_r)) // (R16)
      else $error("count moved while disabled");

   a_gate_low_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      en_r && gate_en_r && !gate_level && !cmd_valid |=> $stable(count_r))
      else $error("count moved with gate low"); // (R16)

   a_reload_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      advance && at_zero && !cmd_valid
      |=> count_r == $past(divisor) - CNT_W'(1)) // (R13)
      else $error("no reload after zero");

   // Pulse holds between input ticks and drops on the next one
   a_pulse_one_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pulse_r && !cmd_valid |=> pulse_r == !$past(advance)) // (R13)
      else $error("pulse length not one input tick");

   a_pulse_at_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(pulse_r) |-> at_zero && $past(at_one)) // (R13)
      else $error("pulse not tied to reaching zero");

endmodule // sample_counter
`default_nettype wire

// [bench/line_partner.sv]
// Model of the external logic wired to the 24 header lines
`timescale 1ns/1ps
`default_nettype none
module line_partner (
   input wire logic [23:0] line_out,
   input wire logic [23:0] line_oe_n,
   input wire logic [23:0] pins,
   output logic [23:0] line_in
);
   // ==========================================================
   // Pin level
   // A driven line shows the device value, an input line the far side value
   assign line_in = (line_out & ~line_oe_n) | (pins & line_oe_n);
endmodule // line_partner
`default_nettype wire

// [bench/dio_ports_with_sample_counter_test.sv]
// Self-checking bench for the digital I/O ports and sample counter
`timescale 1ns/1ps
`default_nettype none
module dio_ports_with_sample_counter_test;
   logic sys_clk, reset_n, awv, wv, bready, arv, rready, awr, wrdy;
   logic bvalid, arr, rvalid, trig;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp;
   logic [3:0] wstrb;
   logic [23:0] pins, lin, lout, oen, m_out, ex;
   logic [7:0] m_dir, d;
   int n_errors, checked, seed, cyc, t0, t1, c, i, p, s, n;

   dio_ports_with_sample_counter dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_in(lin),
      .line_out(lout), .line_oe_n(oen), .conv_trigger(trig));
   line_partner far_side (.line_out(lout), .line_oe_n(oen), .pins(pins),
      .line_in(lin));

   // ==========================================================
   // Clock, cycle count and helpers
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   function automatic logic [23:0] oe_exp(input logic [7:0] x);
      return {{4{x[3]}}, {4{x[0]}}, {8{x[1]}}, {8{x[4]}}};
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("errors=%0d checked=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task tmo;
      n_errors++;
      $display("BAD t=%0t wait ran out", $time);
      close_out();
   endtask

   // ==========================================================
   // Bus master: hold each channel until its ready is sampled
   task wreg(input logic [3:0] idx, input logic [7:0] v);
      int k;
      @(posedge sys_clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h00_0000, v};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (k == 50) tmo();
      chk({30'h0, bresp}, {30'h0, dio_pkg::RESP_OKAY});
   endtask
   task rreg(input logic [3:0] idx, output logic [31:0] v);
      int k;
      @(posedge sys_clk);
      araddr <= {idx, 2'b00};
      arv <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (arr) arv <= 1'b0;
         if (rvalid) break;
      end
      v = rdata;
      rready <= 1'b0;
      if (k == 50) tmo();
   endtask
   task wtrig(output int t);
      int k;
      for (k = 0; k < 1000; k++) begin
         @(posedge sys_clk);
         if (trig === 1'b1) break;
      end
      t = cyc;
      if (k == 1000) tmo();
   endtask
   task quiet(output int cnt);
      cnt = 0;
      repeat (200) begin
         @(posedge sys_clk);
         if (trig !== 1'b0) cnt++;
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {reset_n, awv, wv, bready, arv, rready, awaddr, araddr} = '0;
      wdata = '0;
      wstrb = 4'h1;
      cyc = 0;
      seed = 32'h171e_21ec;
      pins = 24'($random(seed));
      m_out = 24'h00_0000;
      m_dir = 8'h9B;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk({8'h00, oen}, 32'h00ff_ffff);
      rreg(dio_pkg::IDX_DIR, rd);
      chk(rd, 32'h0000_009b);
      rreg(dio_pkg::IDX_PORT_A, rd);
      chk(rd, {24'h00_0000, pins[7:0]});
      rreg(4'h0, rd);
      chk({30'h0, rresp}, {30'h0, dio_pkg::RESP_SLVERR});
      // Random data, then random directions; outputs read back
      for (i = 0; i < 10; i++) begin
         pins <= 24'($random(seed));
         for (p = 0; p < 3; p++) begin
            d = 8'($random(seed));
            wreg(dio_pkg::IDX_PORT_A + 4'(p), d);
            m_out[8*p +: 8] = d;
         end
         d = (8'($random(seed)) & 8'h1B) | 8'h80;
         m_out = m_out & ~(oe_exp(m_dir) & ~oe_exp(d));
         m_dir = d;
         wreg(dio_pkg::IDX_DIR, d);
         chk({8'h00, oen}, {8'h00, oe_exp(d)});
         chk({8'h00, lout & ~oen}, {8'h00, m_out & ~oe_exp(d)});
         ex = (m_out & ~oe_exp(d)) | (pins & oe_exp(d));
         for (p = 0; p < 3; p++) begin
            rreg(dio_pkg::IDX_PORT_A + 4'(p), rd);
            chk(rd, {24'h00_0000, ex[8*p +: 8]});
         end
      end
      // Counter lines: one pulse per n ticks at either clock rate
      wreg(dio_pkg::IDX_DIR, 8'h1B);
      chk({28'h0, oen[23:20]}, 32'h0000_0007);
      for (s = 0; s < 2; s++) begin
         n = s ? 2 : 5;
         wreg(dio_pkg::IDX_CONFIG, s ? 8'h21 : 8'h01);
         wreg(dio_pkg::IDX_CNT_LOW, 8'(n));
         wreg(dio_pkg::IDX_CNT_MID, 8'h00);
         wreg(dio_pkg::IDX_CNT_HIGH, 8'h00);
         wreg(dio_pkg::IDX_CNT_CTL, 8'h02);
         wreg(dio_pkg::IDX_CNT_CTL, 8'h04);
         wtrig(t0);
         wtrig(t0);
         wtrig(t1);
         p = n * (s ? dio_pkg::SLOW_DIV : dio_pkg::FAST_DIV);
         chk(32'(t1 - t0), 32'(p));
      end
      // Trigger source other than the counter blocks the trigger
      wreg(dio_pkg::IDX_CONFIG, 8'h11);
      quiet(c);
      chk(32'(c), 32'h0000_0000);
      // Gate low holds the count, gate high lets it run
      wreg(dio_pkg::IDX_CONFIG, 8'h01);
      pins[20] <= 1'b0;
      wreg(dio_pkg::IDX_CNT_CTL, 8'h10);
      repeat (100) @(posedge sys_clk);
      quiet(c);
      chk(32'(c), 32'h0000_0000);
      pins[20] <= 1'b1;
      wtrig(t0);
      wtrig(t1);
      chk(32'(t1 - t0), 32'(2 * dio_pkg::FAST_DIV));
      // Gate disabled: a low gate pin no longer holds the count
      pins[20] <= 1'b0;
      wreg(dio_pkg::IDX_CNT_CTL, 8'h20);
      wtrig(t0);
      wtrig(t1);
      chk(32'(t1 - t0), 32'(2 * dio_pkg::FAST_DIV));
      // Stop, clear and latch: every count byte reads zero
      wreg(dio_pkg::IDX_CNT_CTL, 8'h08);
      wreg(dio_pkg::IDX_CNT_CTL, 8'h01);
      wreg(dio_pkg::IDX_CNT_CTL, 8'h40);
      for (p = 0; p < 3; p++) begin
         rreg(dio_pkg::IDX_CNT_LOW + 4'(p), rd);
         chk(rd, 32'h0000_0000);
      end
      close_out();
   end
endmodule // dio_ports_with_sample_counter_test
`default_nettype wire
